// >>> sspp_pkg.sv
`default_nettype none
// =============================================
// Shared constants of the serial programming port
package sspp_pkg;
    // =============================================
    // Frame layout
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS  = 7;
    localparam int DATA_BITS  = 16;
    localparam int REG_NUM    = 128;
    localparam int CNT_W      = 5;
    localparam int DIR_POS    = 23;
    localparam int ADDR_HI    = 22;
    localparam int ADDR_LO    = 16;
    localparam int RB_START   = 7;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ  = 1'b1;
    // =============================================
    // Register 0 fields and the frame reference enable
    localparam logic [6:0] R0_ADDR   = 7'h00;
    localparam int         SLEEP_BIT = 0;
    localparam int         RESET_BIT = 1;
    localparam int         CAL_BIT   = 3;
    localparam int         PSYNC_BIT = 14;
    localparam logic [6:0] FREF_ADDR = 7'h48;
    localparam int         FREF_BIT  = 0;
    localparam logic [15:0] R0_HOLD_MASK = 16'h0003;
    // =============================================
    // Programming order limits
    localparam logic [6:0] REQ_TOP = 7'h4B;
    localparam logic [6:0] OPT_TOP = 7'h71;
    localparam logic [6:0] WD_ADDR = 7'h72;
    // =============================================
    // Timing
    localparam int CLK_HZ       = 25000000;
    localparam int CAL_WAIT_MS  = 10;
    localparam int CAL_WAIT_CYC = CAL_WAIT_MS * (CLK_HZ / 1000);
    localparam int SCLK_HALF    = 4;
    // =============================================
    // Host command registers
    localparam logic [3:0] HR_ADDR     = 4'h0;
    localparam logic [3:0] HR_WDATA    = 4'h1;
    localparam logic [3:0] HR_CTRL     = 4'h2;
    localparam logic [3:0] HR_STATUS   = 4'h3;
    localparam logic [3:0] HR_RDATA    = 4'h4;
    localparam logic [3:0] HR_IMG_ADDR = 4'h5;
    localparam logic [3:0] HR_IMG_DATA = 4'h6;
    localparam int CB_WRITE = 0;
    localparam int CB_READ  = 1;
    localparam int CB_INIT  = 2;
    localparam int CB_OPT   = 3;
    localparam int CB_WD    = 4;
    localparam int SB_BUSY  = 0;
    localparam int SB_DONE  = 1;
endpackage : sspp_pkg
`default_nettype wire

// >>> sspp_link_if.sv
`default_nettype none
// =============================================
// Serial programming link between host and device
interface sspp_link_if;
    logic sclk;
    logic select_bar;
    logic sdata;
    logic readback;
    modport dev
    (
        input  sclk,
        input  select_bar,
        input  sdata,
        output readback
    );
    modport host
    (
        output sclk,
        output select_bar,
        output sdata,
        input  readback
    );
endinterface : sspp_link_if
`default_nettype wire

// >>> sspp_device.sv
`default_nettype none
module sspp_device
    import sspp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    sspp_link_if.dev         lnk,
    input  wire logic        strap_sel_a,
    input  wire logic        strap_sel_b,
    input  wire logic        strap_sel_c,
    input  wire logic        sleep_pin_b,
    output logic             pin_mode,
    output logic [2:0]       preset_code,
    output logic             power_down,
    output logic             soft_reset_active,
    output logic             phase_sync_mode,
    output logic             second_rf_output_sysref,
    output logic             calibration_start,
    output logic             commit_strobe,
    output logic [6:0]       commit_addr,
    output logic [15:0]      commit_data
);
    // =============================================
    // Input synchronisers
    localparam int SYNC_W = 7;
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h42;
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] pin_s1_reg;
    logic [SYNC_W-1:0] pin_s2_reg;

    assign pin_raw = {sleep_pin_b, strap_sel_c, strap_sel_b, strap_sel_a,
                      lnk.sdata, lnk.select_bar, lnk.sclk};

    // Every pin is foreign to clk_sys, so each bit gets two flops
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    pin_s1_reg[gi] <= SYNC_RST[gi];
                    pin_s2_reg[gi] <= SYNC_RST[gi];
                end
                else
                begin
                    pin_s1_reg[gi] <= pin_raw[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                end
            end
        end
    endgenerate

    logic sclk_s;
    logic sel_b_s;
    logic sdata_s;
    logic sleep_pin_b_s;
    logic [2:0] strap_s;
    assign sclk_s        = pin_s2_reg[0];
    assign sel_b_s       = pin_s2_reg[1];
    assign sdata_s       = pin_s2_reg[2];
    assign strap_s       = pin_s2_reg[5:3];
    assign sleep_pin_b_s = pin_s2_reg[6];

    // =============================================
    // Edge detection on synchronised link lines
    logic sclk_d_reg;
    logic sel_b_d_reg;
    logic sclk_rise;
    logic sel_rise;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_d_reg  <= 1'b0;
            sel_b_d_reg <= 1'b1;
        end
        else
        begin
            sclk_d_reg  <= sclk_s;
            sel_b_d_reg <= sel_b_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg & ~sel_b_s;
    assign sel_rise  = sel_b_s & ~sel_b_d_reg;

    // =============================================
    // Shift register and bit counter
    logic [FRAME_BITS-1:0] shift_reg;
    logic [CNT_W-1:0]      bit_cnt_reg;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FRAME_BITS);
    localparam logic [CNT_W-1:0] CNT_OVER = CNT_W'(FRAME_BITS + 1);
    localparam logic [CNT_W-1:0] CNT_RB   = CNT_W'(RB_START);

    // Counter saturates past a full frame so long frames never commit
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_reg   <= '0;
            bit_cnt_reg <= '0;
        end
        else if (sel_b_s)
        begin
            bit_cnt_reg <= '0;
        end
        else if (sclk_rise)
        begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], sdata_s};
            if (bit_cnt_reg != CNT_OVER)
                bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
        end
    end

    // =============================================
    // Frame decode
    logic             frame_dir;
    logic [6:0]       frame_addr;
    logic [15:0]      frame_data;
    logic             frame_ok;
    logic             pin_mode_now;
    assign frame_dir  = shift_reg[DIR_POS];
    assign frame_addr = shift_reg[ADDR_HI:ADDR_LO];
    assign frame_data = shift_reg[DATA_BITS-1:0];
    assign pin_mode_now = |strap_s;
    // Commit only complete write frames while under serial control
    assign frame_ok = sel_rise && (bit_cnt_reg == CNT_FULL) &&
                      (frame_dir == DIR_WRITE) && !pin_mode_now;

    // =============================================
    // Register file
    logic [DATA_BITS-1:0] regs [REG_NUM];
    logic                 soft_hold;
    assign soft_hold = regs[R0_ADDR][RESET_BIT] & ~regs[R0_ADDR][SLEEP_BIT];

    // Hold clears everything but the reset and sleep bits of register 0;
    // a register 0 write lands after the hold, so the host can release reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < REG_NUM; i++)
                regs[i] <= '0;
        end
        else
        begin
            if (soft_hold)
            begin
                for (int i = 1; i < REG_NUM; i++)
                    regs[i] <= '0;
                regs[R0_ADDR] <= regs[R0_ADDR] & R0_HOLD_MASK;
            end
            if (frame_ok && (!soft_hold || frame_addr == R0_ADDR))
                regs[frame_addr] <= frame_data;
        end
    end

    // =============================================
    // Readback shifter
    logic [DATA_BITS-1:0] rb_word_reg;
    logic                 rb_active_reg;
    logic [6:0]           rb_addr;
    assign rb_addr = {shift_reg[ADDR_BITS-2:0], sdata_s};

    // Next bit appears one link clock ahead of the host sampling edge
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rb_word_reg   <= '0;
            rb_active_reg <= 1'b0;
            lnk.readback  <= 1'b0;
        end
        else if (sel_b_s)
        begin
            rb_active_reg <= 1'b0;
            lnk.readback  <= 1'b0;
        end
        else if (sclk_rise)
        begin
            if (bit_cnt_reg == CNT_RB)
            begin
                rb_active_reg <= (shift_reg[ADDR_BITS-1] == DIR_READ);
                rb_word_reg   <= regs[rb_addr] << 1;
                lnk.readback  <= (shift_reg[ADDR_BITS-1] == DIR_READ) &
                                 regs[rb_addr][DATA_BITS-1];
            end
            else if (rb_active_reg && bit_cnt_reg < CNT_FULL)
            begin
                lnk.readback <= rb_word_reg[DATA_BITS-1];
                rb_word_reg  <= rb_word_reg << 1;
            end
            else
            begin
                lnk.readback <= 1'b0;
            end
        end
    end

    // =============================================
    // Mode outputs
    logic psync;
    assign psync = regs[R0_ADDR][PSYNC_BIT];

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_mode                <= 1'b0;
            preset_code             <= '0;
            power_down              <= 1'b0;
            soft_reset_active       <= 1'b0;
            phase_sync_mode         <= 1'b0;
            second_rf_output_sysref <= 1'b0;
        end
        else
        begin
            pin_mode                <= pin_mode_now;
            preset_code             <= strap_s;
            power_down              <= regs[R0_ADDR][SLEEP_BIT] | ~sleep_pin_b_s;
            soft_reset_active       <= soft_hold;
            phase_sync_mode         <= psync;
            second_rf_output_sysref <= psync & regs[FREF_ADDR][FREF_BIT];
        end
    end

    // =============================================
    // Commit notice and calibration trigger
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            commit_strobe     <= 1'b0;
            commit_addr       <= '0;
            commit_data       <= '0;
            calibration_start <= 1'b0;
        end
        else
        begin
            commit_strobe     <= frame_ok;
            calibration_start <= frame_ok && frame_addr == R0_ADDR && frame_data[CAL_BIT];
            if (frame_ok)
            begin
                commit_addr <= frame_addr;
                commit_data <= frame_data;
            end
        end
    end
endmodule : sspp_device
`default_nettype wire

// >>> sspp_host.sv
// Design decisions made here: the register offsets and strobed register access.
`default_nettype none
module sspp_host
    import sspp_pkg::*;
#(
    parameter int CAL_WAIT = CAL_WAIT_CYC,
    parameter int HALF     = SCLK_HALF
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    sspp_link_if.host        lnk,
    input  wire logic [3:0]  cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    output logic [15:0]      cmd_rdata
);
    typedef enum { F_IDLE, F_LOW, F_HIGH, F_TAIL, F_GAP } sspp_fstate_t;
    typedef enum { Q_IDLE, Q_ONE, Q_RST1, Q_RST0, Q_LOAD, Q_WAIT, Q_CAL } sspp_qstate_t;

    function automatic logic [FRAME_BITS-1:0] mk_frame(input logic d, input logic [6:0] a,
                                                        input logic [15:0] v);
        mk_frame = {d, a, v};
    endfunction : mk_frame

    // =============================================
    // Software registers and image memory
    logic [6:0]  addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [6:0]  img_addr_reg;
    logic [15:0] image [REG_NUM];
    logic        done_reg;
    logic        opt_reg;
    logic        wd_reg;
    logic        busy;
    sspp_qstate_t q_reg;

    assign busy = (q_reg != Q_IDLE);

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_reg     <= '0;
            wdata_reg    <= '0;
            img_addr_reg <= '0;
        end
        else if (cmd_wr)
        begin
            if (cmd_addr == HR_ADDR)
                addr_reg <= cmd_wdata[6:0];
            if (cmd_addr == HR_WDATA)
                wdata_reg <= cmd_wdata;
            if (cmd_addr == HR_IMG_ADDR)
                img_addr_reg <= cmd_wdata[6:0];
        end
    end

    // Image holds the values software wants written at bring-up
    always_ff @(posedge clk_sys)
    begin
        if (cmd_wr && cmd_addr == HR_IMG_DATA)
            image[img_addr_reg] <= cmd_wdata;
    end

    // Read data valid the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            cmd_rdata <= '0;
        else if (cmd_rd)
        begin
            case (cmd_addr)
                HR_ADDR:     cmd_rdata <= {9'h000, addr_reg};
                HR_WDATA:    cmd_rdata <= wdata_reg;
                HR_STATUS:   cmd_rdata <= {14'h0000, done_reg, busy};
                HR_RDATA:    cmd_rdata <= rdata_reg;
                HR_IMG_ADDR: cmd_rdata <= {9'h000, img_addr_reg};
                default:     cmd_rdata <= '0;
            endcase
        end
    end

    // =============================================
    // Frame engine
    sspp_fstate_t          f_reg;
    logic [FRAME_BITS-1:0] tx_reg;
    logic [CNT_W-1:0]      bit_reg;
    logic [7:0]            div_reg;
    logic                  f_go;
    logic [FRAME_BITS-1:0] f_word;
    logic                  f_done;
    logic                  rb_s1_reg;
    logic                  rb_s2_reg;
    logic                  div_end;
    assign div_end = (div_reg == 8'(HALF - 1));
    assign f_done  = (f_reg == F_GAP) && div_end;

    // Readback comes from another chip, so it is synchronised first
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rb_s1_reg <= 1'b0;
            rb_s2_reg <= 1'b0;
        end
        else
        begin
            rb_s1_reg <= lnk.readback;
            rb_s2_reg <= rb_s1_reg;
        end
    end

    // Data changes on the falling edge so it is stable at the rising one
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            f_reg          <= F_IDLE;
            tx_reg         <= '0;
            bit_reg        <= '0;
            div_reg        <= '0;
            rdata_reg      <= '0;
            lnk.sclk       <= 1'b0;
            lnk.select_bar <= 1'b1;
            lnk.sdata      <= 1'b0;
        end
        else
        begin
            div_reg <= div_end ? 8'h00 : div_reg + 8'h01;
            case (f_reg)
                F_IDLE:
                begin
                    div_reg <= '0;
                    if (f_go)
                    begin
                        tx_reg         <= f_word;
                        lnk.sdata      <= f_word[DIR_POS];
                        lnk.select_bar <= 1'b0;
                        bit_reg        <= '0;
                        f_reg          <= F_LOW;
                    end
                end
                F_LOW:
                    if (div_end)
                    begin
                        lnk.sclk <= 1'b1;
                        if (bit_reg > CNT_W'(RB_START))
                            rdata_reg <= {rdata_reg[DATA_BITS-2:0], rb_s2_reg};
                        f_reg <= F_HIGH;
                    end
                F_HIGH:
                    if (div_end)
                    begin
                        lnk.sclk <= 1'b0;
                        bit_reg  <= bit_reg + CNT_W'(1);
                        if (bit_reg == CNT_W'(FRAME_BITS - 1))
                            f_reg <= F_TAIL;
                        else
                        begin
                            tx_reg    <= tx_reg << 1;
                            lnk.sdata <= tx_reg[DIR_POS-1];
                            f_reg     <= F_LOW;
                        end
                    end
                F_TAIL:
                    if (div_end)
                    begin
                        lnk.select_bar <= 1'b1;
                        f_reg          <= F_GAP;
                    end
                F_GAP:
                    if (div_end)
                        f_reg <= F_IDLE;
                default:
                    f_reg <= F_IDLE;
            endcase
        end
    end

    // =============================================
    // Sequencer
    logic [6:0]  load_reg;
    logic [31:0] wait_reg;
    logic        go_reg;
    logic [15:0] r0_img;
    assign r0_img = image[R0_ADDR];
    assign f_go   = go_reg;

    // Register 0 bit masks used by the bring-up frames
    localparam logic [15:0] RST_ON = 16'h0001 << RESET_BIT;
    localparam logic [15:0] SLP_ON = 16'h0001 << SLEEP_BIT;
    localparam logic [15:0] CAL_ON = 16'h0001 << CAL_BIT;

    always_comb
    begin
        f_word = mk_frame(DIR_WRITE, load_reg, image[load_reg]);
        case (q_reg)
            Q_ONE:   f_word = mk_frame(opt_reg, addr_reg, wdata_reg);
            Q_RST1:  f_word = mk_frame(DIR_WRITE, R0_ADDR, (r0_img | RST_ON) & ~SLP_ON);
            Q_RST0:  f_word = mk_frame(DIR_WRITE, R0_ADDR, r0_img & ~RST_ON);
            Q_CAL:   f_word = mk_frame(DIR_WRITE, R0_ADDR, r0_img | CAL_ON);
            default: f_word = mk_frame(DIR_WRITE, load_reg, image[load_reg]);
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q_reg    <= Q_IDLE;
            go_reg   <= 1'b0;
            load_reg <= '0;
            wait_reg <= '0;
            opt_reg  <= 1'b0;
            wd_reg   <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            go_reg <= 1'b0;
            case (q_reg)
                Q_IDLE:
                    if (cmd_wr && cmd_addr == HR_CTRL)
                    begin
                        opt_reg <= cmd_wdata[CB_OPT];
                        wd_reg  <= cmd_wdata[CB_WD];
                        if (cmd_wdata[CB_INIT])
                        begin
                            done_reg <= 1'b0;
                            q_reg    <= Q_RST1;
                            go_reg   <= 1'b1;
                        end
                        else if (cmd_wdata[CB_WRITE] | cmd_wdata[CB_READ])
                        begin
                            opt_reg <= cmd_wdata[CB_READ];
                            q_reg   <= Q_ONE;
                            go_reg  <= 1'b1;
                        end
                    end
                Q_ONE:
                    if (f_done)
                        q_reg <= Q_IDLE;
                Q_RST1:
                    if (f_done)
                    begin
                        q_reg  <= Q_RST0;
                        go_reg <= 1'b1;
                    end
                Q_RST0:
                    if (f_done)
                    begin
                        load_reg <= wd_reg ? WD_ADDR : (opt_reg ? OPT_TOP : REQ_TOP);
                        q_reg    <= Q_LOAD;
                        go_reg   <= 1'b1;
                    end
                Q_LOAD:
                    if (f_done)
                    begin
                        go_reg <= (load_reg != R0_ADDR);
                        if (load_reg == R0_ADDR)
                        begin
                            wait_reg <= '0;
                            q_reg    <= Q_WAIT;
                        end
                        else if (load_reg == WD_ADDR && !opt_reg)
                            load_reg <= REQ_TOP;
                        else
                            load_reg <= load_reg - 7'h01;
                    end
                Q_WAIT:
                begin
                    wait_reg <= wait_reg + 32'h1;
                    if (wait_reg == 32'(CAL_WAIT - 1))
                    begin
                        q_reg  <= Q_CAL;
                        go_reg <= 1'b1;
                    end
                end
                Q_CAL:
                    if (f_done)
                    begin
                        done_reg <= 1'b1;
                        q_reg    <= Q_IDLE;
                    end
                default:
                    q_reg <= Q_IDLE;
            endcase
        end
    end
endmodule : sspp_host
`default_nettype wire

// >>> sspp_link_assertions.sv
`default_nettype none
// =====
// Link checks
module sspp_link_assertions
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic select_bar,
    input wire logic sdata,
    input wire logic readback
);
    logic [4:0] rise_cnt;
    logic       dir_flag;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Rises per frame; cleared as a frame opens
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            rise_cnt <= 5'h00;
        else if ($fell(select_bar))
            rise_cnt <= 5'h00;
        else if ($rose(sclk) && !select_bar)
            rise_cnt <= rise_cnt + 5'h01;
    // First bit of a frame is its direction
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            dir_flag <= 1'b0;
        else if ($rose(sclk) && !select_bar && rise_cnt == 5'h00)
            dir_flag <= sdata;
    a_sclk_idle: assert property (select_bar |-> !sclk) else $error("sclk moves outside frame");
    a_sel_fall_quiet: assert property ($fell(select_bar) |-> !sclk[*4]) else $error("early sclk");
    a_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("sclk high time");
    a_sdata_hold: assert property (sclk |-> $stable(sdata)) else $error("sdata moved near rise");
    a_sel_gap: assert property ($rose(select_bar) |-> select_bar[*3]) else $error("short frame gap");
    a_frame_len: assert property ($rose(select_bar) |-> rise_cnt == 5'd24) else $error("frame length");
    a_rb_idle: assert property (select_bar[*3] |-> !readback) else $error("readback not idle");
    a_rb_write: assert property (!select_bar && rise_cnt != 5'h00 && !dir_flag |-> !readback)
        else $error("readback in write");
    c_write: cover property ($rose(select_bar) && !dir_flag);
    c_read: cover property ($rose(select_bar) && dir_flag);
    c_rb: cover property (readback);
endmodule : sspp_link_assertions
`default_nettype wire

// >>> test_synth_serial_program_port.sv
`default_nettype none
module test_synth_serial_program_port
    import sspp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] strap = 3'h0;
    logic sleep_pin_b = 1'b1;
    logic [3:0] cmd_addr = 4'h0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [15:0] cmd_rdata, rd_val, commit_data;
    logic pin_mode, power_down, soft_rst, psync, sysref;
    logic [2:0] preset_code;
    logic [6:0] commit_addr;
    logic cal_pulse, commit_strobe;
    int n_commit = 0, n_cal = 0;
    int miscompares = 0;
    int n_compared = 0;
    sspp_link_if lnk ();
    sspp_host #(.CAL_WAIT(50)) u_sspp_host (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
    sspp_device u_sspp_device (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk), .strap_sel_a(strap[0]),
        .strap_sel_b(strap[1]), .strap_sel_c(strap[2]), .sleep_pin_b(sleep_pin_b), .pin_mode(pin_mode),
        .preset_code(preset_code), .power_down(power_down), .soft_reset_active(soft_rst),
        .phase_sync_mode(psync), .second_rf_output_sysref(sysref), .calibration_start(cal_pulse),
        .commit_strobe(commit_strobe), .commit_addr(commit_addr), .commit_data(commit_data));
    sspp_link_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(lnk.sclk),
        .select_bar(lnk.select_bar), .sdata(lnk.sdata), .readback(lnk.readback));
    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;
    // Count one-cycle commit and calibration pulses
    always @(posedge clk_sys)
    begin
        n_commit += int'(commit_strobe);
        n_cal += int'(cal_pulse);
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input logic [15:0] e, input logic [15:0] g, input string n);
        n_compared++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            miscompares++;
        end
    endtask : chk
    task hw(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk_sys);
        cmd_wr <= 1'b0;
    endtask : hw
    // Read data stand from the cycle after the strobe edge until the next read
    task hr(input logic [3:0] a);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk_sys);
        cmd_rd <= 1'b0;
        #1 rd_val = cmd_rdata;
    endtask : hr
    // One command, then poll busy under a bound
    task frame(input logic [4:0] c, input logic [6:0] a, input logic [15:0] d);
        int i;
        hw(HR_ADDR, {9'h000, a});
        hw(HR_WDATA, d);
        hw(HR_CTRL, {11'h000, c});
        rd_val = 16'h0001;
        for (i = 0; i < 20000 && rd_val[SB_BUSY] === 1'b1; i++)
            hr(HR_STATUS);
        chk(16'h0000, 16'(rd_val[SB_BUSY]), "busy");
        repeat (10) @(posedge clk_sys);
    endtask : frame
    // =====
    // Tests
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        frame(5'h01, FREF_ADDR, 16'h0001);
        chk(16'h0048, 16'(commit_addr), "addr");
        chk(16'h0001, commit_data, "data");
        frame(5'h01, R0_ADDR, 16'h4000);
        chk(16'h0001, 16'(psync), "psync");
        chk(16'h0001, 16'(sysref), "sysref");
        frame(5'h02, FREF_ADDR, 16'h0000);
        hr(HR_RDATA);
        chk(16'h0001, rd_val, "rdata");
        $display("test access done");
        frame(5'h01, R0_ADDR, 16'h0001);
        chk(16'h0001, 16'(power_down), "pd_bit");
        frame(5'h01, R0_ADDR, 16'h0000);
        chk(16'h0000, 16'(power_down), "pd_off");
        sleep_pin_b <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(16'h0001, 16'(power_down), "pd_pin");
        sleep_pin_b <= 1'b1;
        frame(5'h01, R0_ADDR, 16'h0002);
        chk(16'h0001, 16'(soft_rst), "soft_rst");
        frame(5'h02, FREF_ADDR, 16'h0000);
        hr(HR_RDATA);
        chk(16'h0000, rd_val, "held");
        frame(5'h01, R0_ADDR, 16'h0000);
        $display("test modes done");
        strap <= 3'h4;
        repeat (6) @(posedge clk_sys);
        chk(16'h0001, 16'(pin_mode), "pin_mode");
        chk(16'h0004, 16'(preset_code), "preset");
        frame(5'h01, FREF_ADDR, 16'h00AA);
        chk(16'h0000, commit_data, "pin_write");
        strap <= 3'h0;
        repeat (6) @(posedge clk_sys);
        chk(16'h0000, 16'(pin_mode), "serial");
        for (int i = 0; i <= int'(WD_ADDR); i++)
        begin
            hw(HR_IMG_ADDR, 16'(i));
            hw(HR_IMG_DATA, 16'(i));
        end
        frame(5'h1C, R0_ADDR, 16'h0000);
        chk(16'h0008, commit_data, "cal");
        chk(16'h0000, 16'(commit_addr), "last");
        hr(HR_STATUS);
        chk(16'h0001, 16'(rd_val[SB_DONE]), "done");
        frame(5'h02, 7'h50, 16'h0000);
        hr(HR_RDATA);
        chk(16'h0050, rd_val, "reg_50");
        frame(5'h02, WD_ADDR, 16'h0000);
        hr(HR_RDATA);
        chk(16'h0072, rd_val, "reg_72");
        frame(5'h01, R0_ADDR, 16'h0008);
        chk(16'h007D, 16'(n_commit), "commits");
        chk(16'h0002, 16'(n_cal), "cal_pulses");
        $display("test init done");
        report_and_stop();
    end
    // Watchdog well past the expected run
    initial
    begin
        #3000000;
        miscompares++;
        report_and_stop();
    end
endmodule : test_synth_serial_program_port
`default_nettype wire
